// ==== osc_ctrl.sv ====
// Purpose: Oscillator control and status register block behind an APB slave.
// Assumes: Status pins are asynchronous and pass the input synchroniser.
// Notes: Zero-wait APB; pready rises in the access phase of every transfer.
//
// Implementation choices: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
module osc_ctrl (
    input wire logic clk_sys, // System clock, 25 MHz
    input wire logic rst, // Synchronous reset, active high
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction, high for write
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    input wire logic clock_fail_pin, // Fail-safe monitor failure level
    input wire logic pll_locked_pin, // PLL lock detector
    input wire logic pll_startup_done_pin, // PLL start-up timer expired
    input wire logic pll_enabled_pin, // PLL enabled
    input wire logic [1:0] cksm_cfg_pin, // Configuration word switch field
    output logic [2:0] new_clock_source_select, // Requested source code
    output logic [1:0] osc_family, // Decoded oscillator family
    output logic pll_select, // Requested source uses the PLL
    output logic [1:0] post_divider, // Decoded fast RC post-divider
    output logic clock_switch_allowed, // Switching permitted
    output logic [15:0] pin_map0, // Pin-select mapping word 0
    output logic [15:0] pin_map1, // Pin-select mapping word 1
    output logic irq // Level interrupt
);
    osc_status_if stat ();

    localparam int NUM_EVENTS_W = osc_ctrl_pkg::NUM_EVENTS;

    logic [2:0] src_sel_reg;
    logic clock_source_lock_reg;
    logic pin_select_write_lock_reg;
    logic clock_fail_flag;
    logic pll_lock_status;
    logic pll_lock_prev_reg;
    logic lock_effective;
    logic [NUM_EVENTS_W-1:0] int_status;
    logic [NUM_EVENTS_W-1:0] int_mask_reg;
    logic [NUM_EVENTS_W-1:0] event_set;
    logic [NUM_EVENTS_W-1:0] event_clr;
    logic [15:0] pin_map0_reg;
    logic [15:0] pin_map1_reg;
    logic setup_phase;
    logic wr_access;
    logic addr_hit;
    logic [31:0] rd_next;
    logic [15:0] ctrl_view;
    logic fail_clear;

    osc_input_sync u_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .pins_async({cksm_cfg_pin, pll_enabled_pin, pll_startup_done_pin, pll_locked_pin, clock_fail_pin}),
        .stat(stat)
    );

    // Bus phase decode; a write lands only on the access edge with pready high
    assign setup_phase = psel && !penable;
    assign wr_access = psel && penable && pready && pwrite;

    // R11 lock status source
    // R12 zero when disabled
    assign pll_lock_status = stat.pll_enabled && (stat.pll_locked || stat.pll_startup_done);

    // R6 lock qualified by config
    assign lock_effective = clock_source_lock_reg && (stat.cksm_cfg == osc_ctrl_pkg::CKSM_SWITCH_ONLY);

    // Control register view; reserved bits read zero
    always_comb begin
        ctrl_view = 16'h0000;
        ctrl_view[osc_ctrl_pkg::SRC_SEL_MSB:osc_ctrl_pkg::SRC_SEL_LSB] = src_sel_reg;
        ctrl_view[osc_ctrl_pkg::CLK_LOCK_BIT] = clock_source_lock_reg;
        ctrl_view[osc_ctrl_pkg::PIN_LOCK_BIT] = pin_select_write_lock_reg;
        // R10 read-only lock bit
        ctrl_view[osc_ctrl_pkg::PLL_LOCK_BIT] = pll_lock_status;
        // R13 unimplemented reads zero
        ctrl_view[osc_ctrl_pkg::UNIMP_BIT] = 1'b0;
        ctrl_view[osc_ctrl_pkg::FAIL_BIT] = clock_fail_flag;
    end

    // Read mux and address decode, evaluated in the setup cycle
    always_comb begin
        rd_next = 32'h00000000;
        addr_hit = 1'b1;
        case (paddr)
            osc_ctrl_pkg::OSC_CTRL_OFS: begin
                rd_next = {16'h0000, ctrl_view};
            end
            osc_ctrl_pkg::INT_STATUS_OFS: begin
                rd_next = {30'h0000000, int_status};
            end
            osc_ctrl_pkg::INT_MASK_OFS: begin
                rd_next = {30'h0000000, int_mask_reg};
            end
            osc_ctrl_pkg::PIN_MAP0_OFS: begin
                rd_next = {16'h0000, pin_map0_reg};
            end
            osc_ctrl_pkg::PIN_MAP1_OFS: begin
                rd_next = {16'h0000, pin_map1_reg};
            end
            default: begin
                addr_hit = 1'b0;
            end
        endcase
    end

    // Answer registered at setup so the access phase sees it at once
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= setup_phase;
            pslverr <= setup_phase && !addr_hit;
            prdata <= (setup_phase && !pwrite) ? rd_next : 32'h00000000;
        end
    end

    // Control fields; the source field freezes while the lock acts
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            src_sel_reg <= osc_ctrl_pkg::SRC_SEL_RESET;
            clock_source_lock_reg <= 1'b0;
            pin_select_write_lock_reg <= 1'b0;
        end else if (wr_access && paddr == osc_ctrl_pkg::OSC_CTRL_OFS) begin
            // R6 switch blocked
            // R7 switch permitted
            if (!lock_effective) begin
                src_sel_reg <= pwdata[osc_ctrl_pkg::SRC_SEL_MSB:osc_ctrl_pkg::SRC_SEL_LSB];
            end
            clock_source_lock_reg <= pwdata[osc_ctrl_pkg::CLK_LOCK_BIT];
            pin_select_write_lock_reg <= pwdata[osc_ctrl_pkg::PIN_LOCK_BIT];
        end
    end

    // R15 write zero clears
    assign fail_clear = wr_access && paddr == osc_ctrl_pkg::OSC_CTRL_OFS && !pwdata[osc_ctrl_pkg::FAIL_BIT];

    // R14 monitor sets flag
    // R16 held until cleared
    sticky_flag u_fail (
        .clk_sys(clk_sys),
        .rst(rst),
        .set(stat.clock_fail),
        .clr(fail_clear),
        .q(clock_fail_flag)
    );

    // Remember lock status to catch a loss of lock
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pll_lock_prev_reg <= 1'b0;
        end else begin
            pll_lock_prev_reg <= pll_lock_status;
        end
    end

    // Interrupt events; status bits clear by writing a one
    always_comb begin
        event_set = '0;
        event_set[osc_ctrl_pkg::EV_CLOCK_FAIL] = stat.clock_fail;
        event_set[osc_ctrl_pkg::EV_LOCK_LOST] = pll_lock_prev_reg && !pll_lock_status;
        event_clr = (wr_access && paddr == osc_ctrl_pkg::INT_STATUS_OFS) ? pwdata[NUM_EVENTS_W-1:0] : '0;
    end

    generate
        for (genvar i = 0; i < NUM_EVENTS_W; i++) begin : g_ev
            sticky_flag u_ev (
                .clk_sys(clk_sys),
                .rst(rst),
                .set(event_set[i]),
                .clr(event_clr[i]),
                .q(int_status[i])
            );
        end
    endgenerate

    // Mask register
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            int_mask_reg <= osc_ctrl_pkg::INT_MASK_RESET;
        end else if (wr_access && paddr == osc_ctrl_pkg::INT_MASK_OFS) begin
            int_mask_reg <= pwdata[NUM_EVENTS_W-1:0];
        end
    end

    // Pin-select mapping words; locking guards against stray firmware writes
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pin_map0_reg <= osc_ctrl_pkg::PIN_MAP_RESET;
            pin_map1_reg <= osc_ctrl_pkg::PIN_MAP_RESET;
        end else if (wr_access && !pin_select_write_lock_reg) begin
            // R8 locked writes ignored
            // R9 unlocked writes accepted
            if (paddr == osc_ctrl_pkg::PIN_MAP0_OFS) begin
                pin_map0_reg <= pwdata[15:0];
            end
            if (paddr == osc_ctrl_pkg::PIN_MAP1_OFS) begin
                pin_map1_reg <= pwdata[15:0];
            end
        end
    end

    // Decoded source outputs, registered so every output leaves a flop
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            new_clock_source_select <= osc_ctrl_pkg::SRC_SEL_RESET;
            osc_family <= osc_ctrl_pkg::OSC_FAST_RC;
            pll_select <= 1'b0;
            post_divider <= osc_ctrl_pkg::DIV_NONE;
        end else begin
            new_clock_source_select <= src_sel_reg;
            case (osc_ctrl_pkg::new_source_t'(src_sel_reg))
                // R1 fast RC codes
                osc_ctrl_pkg::SRC_FAST_RC, osc_ctrl_pkg::SRC_FAST_RC_PLL: begin
                    osc_family <= osc_ctrl_pkg::OSC_FAST_RC;
                    pll_select <= src_sel_reg[0];
                    post_divider <= osc_ctrl_pkg::DIV_NONE;
                end
                // R2 primary codes
                osc_ctrl_pkg::SRC_PRI, osc_ctrl_pkg::SRC_PRI_PLL: begin
                    osc_family <= osc_ctrl_pkg::OSC_PRIMARY;
                    pll_select <= src_sel_reg[0];
                    post_divider <= osc_ctrl_pkg::DIV_NONE;
                end
                // R3 secondary oscillator
                osc_ctrl_pkg::SRC_SEC: begin
                    osc_family <= osc_ctrl_pkg::OSC_SECONDARY;
                    pll_select <= 1'b0;
                    post_divider <= osc_ctrl_pkg::DIV_NONE;
                end
                // R3 low-power RC
                osc_ctrl_pkg::SRC_LOW_POWER_RC: begin
                    osc_family <= osc_ctrl_pkg::OSC_LOW_POWER_RC;
                    pll_select <= 1'b0;
                    post_divider <= osc_ctrl_pkg::DIV_NONE;
                end
                // R4 fixed divide-by-16
                osc_ctrl_pkg::SRC_FAST_RC_DIV16: begin
                    osc_family <= osc_ctrl_pkg::OSC_FAST_RC;
                    pll_select <= 1'b0;
                    post_divider <= osc_ctrl_pkg::DIV_BY_16;
                end
                // R5 programmable divide-by-n
                default: begin
                    osc_family <= osc_ctrl_pkg::OSC_FAST_RC;
                    pll_select <= 1'b0;
                    post_divider <= osc_ctrl_pkg::DIV_BY_N;
                end
            endcase
        end
    end

    // Switch permission and outputs that mirror registers
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            clock_switch_allowed <= 1'b0;
            pin_map0 <= osc_ctrl_pkg::PIN_MAP_RESET;
            pin_map1 <= osc_ctrl_pkg::PIN_MAP_RESET;
            irq <= 1'b0;
        end else begin
            // R7 allowed unless locked
            clock_switch_allowed <= !lock_effective;
            pin_map0 <= pin_map0_reg;
            pin_map1 <= pin_map1_reg;
            irq <= |(int_status & int_mask_reg);
        end
    end

    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    src_write_hold_a: assert property ( // R6
        (wr_access && paddr == osc_ctrl_pkg::OSC_CTRL_OFS && lock_effective) |=> $stable(src_sel_reg))
        else $error("source field changed while clock lock acted");
    src_write_take_a: assert property ( // R7
        (wr_access && paddr == osc_ctrl_pkg::OSC_CTRL_OFS && !lock_effective)
        |=> src_sel_reg == $past(pwdata[10:8]) ##1 new_clock_source_select == $past(src_sel_reg))
        else $error("source field write not taken");
    pin_lock_hold_a: assert property ( // R8
        (wr_access && pin_select_write_lock_reg) |=> $stable(pin_map0_reg) && $stable(pin_map1_reg))
        else $error("pin map written while locked");
    pin_map_take_a: assert property ( // R9
        (wr_access && !pin_select_write_lock_reg && paddr == osc_ctrl_pkg::PIN_MAP0_OFS)
        |=> pin_map0_reg == $past(pwdata[15:0]))
        else $error("pin map write lost");
    pll_lock_view_a: assert property ( // R11
        ctrl_view[5] == (stat.pll_enabled && (stat.pll_locked || stat.pll_startup_done)))
        else $error("lock status bit wrong");
    unimp_zero_a: assert property ( // R13
        (setup_phase && !pwrite && paddr == osc_ctrl_pkg::OSC_CTRL_OFS) |=> prdata[4] == 1'b0 && prdata[31:11] == '0)
        else $error("reserved bits read nonzero");
    fail_set_a: assert property ( // R14
        stat.clock_fail |=> clock_fail_flag ##2 (irq || !int_mask_reg[0] || $past(event_clr[0])))
        else $error("clock fail not flagged");
    fail_hold_a: assert property ( // R16
        (clock_fail_flag && !fail_clear) |=> clock_fail_flag)
        else $error("clock fail flag dropped");
    fail_clear_a: assert property ( // R15
        (fail_clear && !stat.clock_fail) |=> !clock_fail_flag)
        else $error("clock fail flag not cleared");
    apb_answer_a: assert property (
        setup_phase |=> pready ##1 !pready || setup_phase)
        else $error("ready not one cycle after setup");

    write_cover_c: cover property (wr_access && paddr == osc_ctrl_pkg::OSC_CTRL_OFS ##1 lock_effective);
    fail_cover_c: cover property (stat.clock_fail ##[1:5] fail_clear);
    irq_cover_c: cover property ($rose(irq));
    lockloss_cover_c: cover property (event_set[1]);
endmodule : osc_ctrl

// ==== osc_ctrl_pkg.sv ====
// Purpose: Constants and types for the oscillator control and status block.
// Assumes: APB slave with 32-bit data, one aligned word per register.
// Notes: Register offsets are byte addresses.
//
// What this block does
// R1 - Bits 10 to 8 hold the requested new clock source; 000 is the fast RC and 001 the fast RC through the PLL.
// R2 - Code 010 selects the primary oscillator directly and code 011 the primary oscillator through the PLL.
// R3 - Code 100 selects the secondary oscillator and code 101 the low-power RC oscillator.
// R4 - Code 110 selects the fast RC oscillator followed by a fixed divide-by-16.
// R5 - Code 111 selects the fast RC oscillator followed by a programmable divide-by-n.
// R6 - The clock lock bit 7 acts only when the switch configuration is 0b01, and then blocks clock switching.
// R7 - With the clock lock bit clear, clock-switch requests may change the system clock source.
// R8 - With the pin-select lock bit 6 set, writes to the pin-select mapping registers are ignored.
// R9 - With the pin-select lock bit clear, writes to the pin-select mapping registers are accepted.
// R10 - The PLL lock status bit 5 is read-only and writes do not change it.
// R11 - The PLL lock status bit reads one when the PLL is locked or its start-up timer has expired.
// R12 - It reads zero when the PLL is out of lock, still starting up or disabled.
// R13 - Bit 4 is unimplemented and always reads zero.
// R14 - The clock-fail flag at bit 3 is set when the fail-safe monitor detects a clock failure.
// R15 - Software may read the clock-fail flag and clear it by writing, and the flag then clears.
// R16 - Once set, the clock-fail flag holds until software clears it or reset occurs.
package osc_ctrl_pkg;
    // Register byte offsets
    localparam logic [7:0] OSC_CTRL_OFS = 8'h00;
    localparam logic [7:0] INT_STATUS_OFS = 8'h04;
    localparam logic [7:0] INT_MASK_OFS = 8'h08;
    localparam logic [7:0] PIN_MAP0_OFS = 8'h0c;
    localparam logic [7:0] PIN_MAP1_OFS = 8'h10;
    // Control register field positions
    localparam int SRC_SEL_LSB = 8;
    localparam int SRC_SEL_MSB = 10;
    localparam int CLK_LOCK_BIT = 7;
    localparam int PIN_LOCK_BIT = 6;
    localparam int PLL_LOCK_BIT = 5;
    localparam int UNIMP_BIT = 4;
    localparam int FAIL_BIT = 3;
    // Interrupt status bit positions
    localparam int EV_CLOCK_FAIL = 0;
    localparam int EV_LOCK_LOST = 1;
    localparam int NUM_EVENTS = 2;
    // Values after reset
    localparam logic [2:0] SRC_SEL_RESET = 3'h0;
    localparam logic [15:0] PIN_MAP_RESET = 16'h0000;
    localparam logic [NUM_EVENTS-1:0] INT_MASK_RESET = 2'h0;
    // Switch configuration value under which the clock lock acts
    localparam logic [1:0] CKSM_SWITCH_ONLY = 2'h1;
    localparam int SYNC_STAGES = 2;
    // New clock source encodings
    typedef enum logic [2:0] {
        SRC_FAST_RC = 3'h0,
        SRC_FAST_RC_PLL = 3'h1,
        SRC_PRI = 3'h2,
        SRC_PRI_PLL = 3'h3,
        SRC_SEC = 3'h4,
        SRC_LOW_POWER_RC = 3'h5,
        SRC_FAST_RC_DIV16 = 3'h6,
        SRC_FAST_RC_DIVN = 3'h7
    } new_source_t;
    // Oscillator family driven by the selection
    typedef enum logic [1:0] {
        OSC_FAST_RC = 2'h0,
        OSC_PRIMARY = 2'h1,
        OSC_SECONDARY = 2'h2,
        OSC_LOW_POWER_RC = 2'h3
    } osc_family_t;
    // Post-divider applied after the fast RC oscillator
    typedef enum logic [1:0] {
        DIV_NONE = 2'h0,
        DIV_BY_16 = 2'h1,
        DIV_BY_N = 2'h2
    } post_div_t;
endpackage : osc_ctrl_pkg

// ==== osc_status_if.sv ====
// Purpose: Carries synchronised status levels from the input stage to the register logic.
// Assumes: One clock domain, clk_sys.
// Notes: All members are levels already past two flip-flops.
`timescale 1ns/10ps
interface osc_status_if;
    logic clock_fail; // Monitor reports a failed clock
    logic pll_locked; // PLL in lock
    logic pll_startup_done; // PLL start-up timer expired
    logic pll_enabled; // PLL powered and running
    logic [1:0] cksm_cfg; // Switch and monitor configuration
    modport src (output clock_fail, pll_locked, pll_startup_done, pll_enabled, cksm_cfg);
    modport dst (input clock_fail, pll_locked, pll_startup_done, pll_enabled, cksm_cfg);
endinterface : osc_status_if

// ==== osc_input_sync.sv ====
// Purpose: Brings the asynchronous status pins into clk_sys.
// Assumes: Each pin is a slow level.
// Notes: Only the second stage is visible outside.
`timescale 1ns/10ps
module osc_input_sync (
    input wire logic clk_sys, // System clock
    input wire logic rst, // Synchronous reset, active high
    input wire logic [5:0] pins_async, // Raw status pins
    osc_status_if.src stat // Synchronised levels
);
    logic [5:0] stage1_reg;
    logic [5:0] stage2_reg;

    // Two flops per pin; the first stage feeds only the second
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            stage1_reg <= 6'h00;
            stage2_reg <= 6'h00;
        end else begin
            stage1_reg <= pins_async;
            stage2_reg <= stage1_reg;
        end
    end

    assign stat.clock_fail = stage2_reg[0];
    assign stat.pll_locked = stage2_reg[1];
    assign stat.pll_startup_done = stage2_reg[2];
    assign stat.pll_enabled = stage2_reg[3];
    assign stat.cksm_cfg = stage2_reg[5:4];
endmodule : osc_input_sync

// ==== sticky_flag.sv ====
// Purpose: One sticky flag, set by hardware and cleared by software.
// Assumes: Set and clear are single-cycle or level terms on clk_sys.
// Notes: Set beats clear so an event in the clearing cycle survives.
`timescale 1ns/10ps
module sticky_flag (
    input wire logic clk_sys, // System clock
    input wire logic rst, // Synchronous reset, active high
    input wire logic set, // Hardware event
    input wire logic clr, // Software clear
    output logic q // Flag value
);
    // Set wins over clear; holds otherwise
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            q <= 1'b0;
        end else if (set) begin
            q <= 1'b1;
        end else if (clr) begin
            q <= 1'b0;
        end
    end
endmodule : sticky_flag

// ==== tb_top.sv ====
// Purpose: Self-checking bench for the oscillator control block over APB.
// Assumes: Zero-wait APB slave; status pins pass a two-stage synchroniser.
// Notes: Design-side assertions live in the design files.
`timescale 1ns/10ps
module tb_top;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, irq;
    logic clock_fail_pin = 1'b0, pll_locked_pin = 1'b0, pll_startup_done_pin = 1'b0, pll_enabled_pin = 1'b0;
    logic [1:0] cksm_cfg_pin = 2'h0, osc_family, post_divider;
    logic [2:0] new_clock_source_select;
    logic pll_select, clock_switch_allowed;
    logic [15:0] pin_map0, pin_map1;
    int num_errors = 0;
    int samples_checked = 0;
    // Expected decode per source code, code 0 in the low bits
    localparam logic [15:0] FAM_TAB = 16'h0e50;
    localparam logic [7:0] PLL_TAB = 8'h0a;
    localparam logic [15:0] DIV_TAB = 16'h9000;

    osc_ctrl dut (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .clock_fail_pin(clock_fail_pin), .pll_locked_pin(pll_locked_pin),
        .pll_startup_done_pin(pll_startup_done_pin), .pll_enabled_pin(pll_enabled_pin),
        .cksm_cfg_pin(cksm_cfg_pin), .new_clock_source_select(new_clock_source_select),
        .osc_family(osc_family), .pll_select(pll_select), .post_divider(post_divider),
        .clock_switch_allowed(clock_switch_allowed), .pin_map0(pin_map0), .pin_map1(pin_map1), .irq(irq));

    // 25 MHz system clock
    always #20 clk_sys = ~clk_sys;

    task automatic print_verdict;
        $display("Checks made: %0d, mismatches: %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : print_verdict

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] seen);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // One APB transfer; waits for pready, only the watchdog ends a hang
    task automatic apb_xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
                            output logic [31:0] rd, output logic err);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1) begin
            @(posedge clk_sys);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb_xfer

    task automatic wr(input logic [7:0] addr, input logic [31:0] wd);
        logic [31:0] rd;
        logic err;
        apb_xfer(1'b1, addr, wd, rd, err);
    endtask : wr

    task automatic rd_chk(input string name, input logic [7:0] addr, input logic [31:0] exp);
        logic [31:0] rd;
        logic err;
        apb_xfer(1'b0, addr, 32'h0, rd, err);
        check(name, exp, rd);
        check({name, "_err"}, 32'h0, {31'h0, err});
    endtask : rd_chk

    function automatic logic [31:0] ctrl_word(input logic [2:0] src, input logic clk_lk,
                                              input logic io_lk, input logic fail);
        return (32'(src) << osc_ctrl_pkg::SRC_SEL_LSB) | (32'(clk_lk) << osc_ctrl_pkg::CLK_LOCK_BIT)
            | (32'(io_lk) << osc_ctrl_pkg::PIN_LOCK_BIT) | (32'(fail) << osc_ctrl_pkg::FAIL_BIT);
    endfunction : ctrl_word

    // Main sequence; waits of a few cycles cover the registered outputs and synchroniser
    initial begin
        logic [31:0] rd;
        logic err;
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (4) @(posedge clk_sys);
        rd_chk("ctrl_reset", osc_ctrl_pkg::OSC_CTRL_OFS, 32'h0);
        apb_xfer(1'b0, 8'h40, 32'h0, rd, err);
        check("unmapped_err", 32'h1, {31'h0, err});
        // Every source code and its decoded outputs
        for (int c = 0; c < 8; c++) begin
            wr(osc_ctrl_pkg::OSC_CTRL_OFS, ctrl_word(3'(c), 1'b0, 1'b0, 1'b1) | 32'h10 | 32'h20);
            rd_chk("src_readback", osc_ctrl_pkg::OSC_CTRL_OFS, ctrl_word(3'(c), 1'b0, 1'b0, 1'b0));
            repeat (3) @(posedge clk_sys);
            check("src_out", 32'(c), 32'(new_clock_source_select));
            check("family", 32'(FAM_TAB[c*2 +: 2]), 32'(osc_family));
            check("pll_sel", 32'(PLL_TAB[c]), 32'(pll_select));
            check("post_div", 32'(DIV_TAB[c*2 +: 2]), 32'(post_divider));
        end
        // Clock lock acts only under switch-only configuration
        cksm_cfg_pin <= 2'h1;
        repeat (5) @(posedge clk_sys);
        wr(osc_ctrl_pkg::OSC_CTRL_OFS, ctrl_word(3'h2, 1'b1, 1'b0, 1'b0));
        wr(osc_ctrl_pkg::OSC_CTRL_OFS, ctrl_word(3'h5, 1'b1, 1'b0, 1'b0));
        rd_chk("src_locked", osc_ctrl_pkg::OSC_CTRL_OFS, ctrl_word(3'h2, 1'b1, 1'b0, 1'b0));
        repeat (2) @(posedge clk_sys);
        check("switch_blocked", 32'h0, 32'(clock_switch_allowed));
        cksm_cfg_pin <= 2'h0;
        repeat (5) @(posedge clk_sys);
        wr(osc_ctrl_pkg::OSC_CTRL_OFS, ctrl_word(3'h5, 1'b1, 1'b0, 1'b0));
        rd_chk("src_cfg_off", osc_ctrl_pkg::OSC_CTRL_OFS, ctrl_word(3'h5, 1'b1, 1'b0, 1'b0));
        wr(osc_ctrl_pkg::OSC_CTRL_OFS, ctrl_word(3'h3, 1'b0, 1'b0, 1'b0));
        rd_chk("src_unlocked", osc_ctrl_pkg::OSC_CTRL_OFS, ctrl_word(3'h3, 1'b0, 1'b0, 1'b0));
        repeat (2) @(posedge clk_sys);
        check("switch_allowed", 32'h1, 32'(clock_switch_allowed));
        // Pin-select lock blocks mapping writes
        wr(osc_ctrl_pkg::PIN_MAP0_OFS, 32'h0000_1234);
        wr(osc_ctrl_pkg::OSC_CTRL_OFS, ctrl_word(3'h0, 1'b0, 1'b1, 1'b0));
        wr(osc_ctrl_pkg::PIN_MAP0_OFS, 32'h0000_5555);
        wr(osc_ctrl_pkg::PIN_MAP1_OFS, 32'h0000_beef);
        rd_chk("map0_locked", osc_ctrl_pkg::PIN_MAP0_OFS, 32'h0000_1234);
        rd_chk("map1_locked", osc_ctrl_pkg::PIN_MAP1_OFS, 32'h0);
        check("map0_port", 32'h1234, 32'(pin_map0));
        wr(osc_ctrl_pkg::OSC_CTRL_OFS, ctrl_word(3'h0, 1'b0, 1'b0, 1'b0));
        wr(osc_ctrl_pkg::PIN_MAP1_OFS, 32'hffff_beef);
        rd_chk("map1_open", osc_ctrl_pkg::PIN_MAP1_OFS, 32'h0000_beef);
        repeat (2) @(posedge clk_sys);
        check("map1_port", 32'hbeef, 32'(pin_map1));
        // Clock failure: sticky flag, event bit, mask and clears
        clock_fail_pin <= 1'b1;
        repeat (3) @(posedge clk_sys);
        clock_fail_pin <= 1'b0;
        repeat (6) @(posedge clk_sys);
        rd_chk("fail_set", osc_ctrl_pkg::OSC_CTRL_OFS, ctrl_word(3'h0, 1'b0, 1'b0, 1'b1));
        rd_chk("ev_status", osc_ctrl_pkg::INT_STATUS_OFS, 32'h1);
        check("irq_masked", 32'h0, 32'(irq));
        wr(osc_ctrl_pkg::INT_MASK_OFS, 32'h1);
        repeat (3) @(posedge clk_sys);
        check("irq_on", 32'h1, 32'(irq));
        wr(osc_ctrl_pkg::OSC_CTRL_OFS, ctrl_word(3'h0, 1'b0, 1'b0, 1'b1));
        rd_chk("fail_keep", osc_ctrl_pkg::OSC_CTRL_OFS, ctrl_word(3'h0, 1'b0, 1'b0, 1'b1));
        wr(osc_ctrl_pkg::OSC_CTRL_OFS, ctrl_word(3'h0, 1'b0, 1'b0, 1'b0));
        rd_chk("fail_clear", osc_ctrl_pkg::OSC_CTRL_OFS, 32'h0);
        wr(osc_ctrl_pkg::INT_STATUS_OFS, 32'h1);
        repeat (3) @(posedge clk_sys);
        check("irq_off", 32'h0, 32'(irq));
        // PLL lock status follows lock or start-up timer, reads zero otherwise
        pll_enabled_pin <= 1'b1;
        pll_locked_pin <= 1'b1;
        repeat (5) @(posedge clk_sys);
        rd_chk("pll_locked", osc_ctrl_pkg::OSC_CTRL_OFS, 32'h20);
        pll_locked_pin <= 1'b0;
        pll_startup_done_pin <= 1'b1;
        repeat (5) @(posedge clk_sys);
        rd_chk("pll_timer", osc_ctrl_pkg::OSC_CTRL_OFS, 32'h20);
        wr(osc_ctrl_pkg::OSC_CTRL_OFS, 32'h0);
        rd_chk("pll_ro", osc_ctrl_pkg::OSC_CTRL_OFS, 32'h20);
        pll_startup_done_pin <= 1'b0;
        repeat (5) @(posedge clk_sys);
        rd_chk("pll_unlocked", osc_ctrl_pkg::OSC_CTRL_OFS, 32'h0);
        rd_chk("ev_lock_lost", osc_ctrl_pkg::INT_STATUS_OFS, 32'h2);
        // A failure flag set again is cleared by a reset in mid-run
        clock_fail_pin <= 1'b1;
        repeat (3) @(posedge clk_sys);
        clock_fail_pin <= 1'b0;
        repeat (4) @(posedge clk_sys);
        rd_chk("fail_again", osc_ctrl_pkg::OSC_CTRL_OFS, 32'h8);
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        rd_chk("fail_reset", osc_ctrl_pkg::OSC_CTRL_OFS, 32'h0);
        check("irq_reset", 32'h0, 32'(irq));
        print_verdict();
    end

    // Watchdog well beyond the expected run length
    initial begin
        repeat (5000) @(posedge clk_sys);
        num_errors++;
        $display("Error watchdog expected completion seen timeout");
        print_verdict();
    end
endmodule : tb_top
